// [sfcfe_regs.vh]
// Constants for the serial flash command front end
`ifndef SFCFE_REGS_VH
`define SFCFE_REGS_VH
`define SFCFE_OP_DREAD 8'h3B
`define SFCFE_OP_D2IO 8'hBB
`define SFCFE_OP_D2IOW 8'h92
`define SFCFE_OP_QREAD 8'h6B
`define SFCFE_OP_Q4IO 8'hEB
`define SFCFE_OP_Q4IOW 8'h94
`define SFCFE_OP_FREAD 8'h0B
`define SFCFE_OP_READ 8'h03
`define SFCFE_OP_DTRF 8'h0D
`define SFCFE_OP_DTR2 8'hBD
`define SFCFE_OP_DTR4 8'hED
`define SFCFE_OP_QPIEN 8'h38
`define SFCFE_OP_QPIDIS 8'hFF
`define SFCFE_OP_RESET_ENABLE_CMD 8'h66
`define SFCFE_OP_RST 8'h99
`define SFCFE_OP_WREN 8'h06
`define SFCFE_OP_WRDI 8'h04
`define SFCFE_OP_WRSR 8'h01
`define SFCFE_OP_SE 8'h20
`define SFCFE_OP_BE 8'hD8
`define SFCFE_OP_CE 8'h60
`define SFCFE_OP_PP 8'h02
`define SFCFE_OP_RDSR 8'h05
`define SFCFE_RESET_TIME_NS 30000
`define SFCFE_CLK_PERIOD_NS 5
`define SFCFE_RESET_CYCLES (`SFCFE_RESET_TIME_NS / `SFCFE_CLK_PERIOD_NS)
`define SFCFE_FIFO_DEPTH 8
`define SFCFE_FIFO_AW 3
`endif

// [sfcfe_fifo.v]
// Parameterised valid/ready FIFO
`timescale 1ns/100ps
module sfcfe_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW = 3
)(
	input wire core_clk,
	input wire reset_n,
	input wire flush,
	input wire [WIDTH-1:0] inData,
	input wire inValid,
	output wire inReady,
	output reg [WIDTH-1:0] outData,
	output reg outValid,
	input wire outReady
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0] wrPtr_reg;
	reg [AW:0] rdPtr_reg;
	wire empty = (wrPtr_reg == rdPtr_reg);
	wire full = (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]) && (wrPtr_reg[AW] != rdPtr_reg[AW]);
	wire loadOut = !empty && (!outValid || outReady);
	assign inReady = !full;
	always @(posedge core_clk)
	begin
		if (inValid && !full)
			mem[wrPtr_reg[AW-1:0]] <= inData;
	end
	always @(posedge core_clk)
	begin
		if (!reset_n || flush)
		begin
			wrPtr_reg <= {(AW+1){1'b0}};
			rdPtr_reg <= {(AW+1){1'b0}};
			outValid <= 1'b0;
			outData <= {WIDTH{1'b0}};
		end
		else
		begin
			if (inValid && !full)
				wrPtr_reg <= wrPtr_reg + 1'b1;
			if (loadOut)
			begin
				outData <= mem[rdPtr_reg[AW-1:0]];
				outValid <= 1'b1;
				rdPtr_reg <= rdPtr_reg + 1'b1;
			end
			else if (outReady)
				outValid <= 1'b0;
		end
	end
endmodule

// [sfcfe_front_end.v]
// Serial flash command front end: framing, lane modes, pause, reset sequence
`timescale 1ns/100ps
`include "sfcfe_regs.vh"
module sfcfe_front_end #(
	parameter RESET_CYCLES = `SFCFE_RESET_CYCLES
)(
	input wire core_clk,
	input wire reset_n,
	input wire serialClk,
	input wire chipSelect_n,
	input wire [3:0] dataLineIn,
	output reg [3:0] dataLineOut,
	output reg [3:0] dataLineOe,
	input wire quadEnableBit,
	input wire writeBusy,
	input wire rangeProtected,
	output reg [7:0] opcode,
	output reg cmdStart,
	output reg cmdExecute,
	output wire [7:0] rxData,
	output wire rxValid,
	input wire rxReady,
	input wire [7:0] txData,
	input wire txValid,
	output wire txReady,
	output reg qpiMode,
	output reg resetBusy,
	output reg softReset
);
	localparam S_IDLE = 5'b00001;
	localparam S_OPC = 5'b00010;
	localparam S_RX = 5'b00100;
	localparam S_TX = 5'b01000;
	localparam S_STANDBY = 5'b10000;

	reg [3:0] dinA_reg, dinB_reg;
	reg sclkA_reg, sclkB_reg, sclkPrev_reg, csA_reg, csB_reg, csPrev_reg;
	always @(posedge core_clk)
	begin
		sclkA_reg <= serialClk;
		sclkB_reg <= sclkA_reg;
		csA_reg <= chipSelect_n;
		csB_reg <= csA_reg;
		dinA_reg <= dataLineIn;
		dinB_reg <= dinA_reg;
		sclkPrev_reg <= sclkB_reg;
		csPrev_reg <= csB_reg;
	end
	// Mode 0 and 3 both reduce to edges seen while selected
	wire sclkRise = sclkB_reg && !sclkPrev_reg && !csB_reg;
	wire sclkFall = !sclkB_reg && sclkPrev_reg && !csB_reg;
	wire csFall = !csB_reg && csPrev_reg;
	wire csRise = csB_reg && !csPrev_reg;

	reg [4:0] state_reg;
	reg [1:0] lanes_reg;
	reg ddr_reg, isWrite_reg, pause_reg, gotRstEn_reg;
	reg [3:0] txOe_reg;
	reg [7:0] shift_reg, txShift_reg;
	reg [2:0] bitCnt_reg;
	reg [15:0] rstCnt_reg;
	reg rxPush_reg;
	reg [7:0] rxByte_reg;
	wire fifoInReady;

	// Pause pin is line three; inactive with quad enable or four-wire mode
	wire pauseAllowed = !quadEnableBit && !qpiMode && !(lanes_reg == 2'd2);
	wire pausePin = dinB_reg[3];
	wire linkLive = !pause_reg;
	wire step = linkLive && (sclkRise || (ddr_reg && sclkFall));
	wire [2:0] perStep = (lanes_reg == 2'd2) ? 3'd4 : (lanes_reg == 2'd1) ? 3'd2 : 3'd1;

	// Shift in MSB first by active lane count
	reg [7:0] shiftNext;
	always @*
	begin
		shiftNext = shift_reg;
		case (lanes_reg)
			2'd2: shiftNext = {shift_reg[3:0], dinB_reg};
			2'd1: shiftNext = {shift_reg[5:0], dinB_reg[1:0]};
			default: shiftNext = {shift_reg[6:0], dinB_reg[0]};
		endcase
	end
	wire [3:0] cntNext = {1'b0, bitCnt_reg} + {1'b0, perStep};
	wire byteDone = cntNext[3];

	// Opcode decode
	reg known, rdCmd, wrCmd, dualCmd, quadCmd, ddrCmd;
	always @*
	begin
		known = 1'b1;
		rdCmd = 1'b0;
		wrCmd = 1'b0;
		dualCmd = 1'b0;
		quadCmd = 1'b0;
		ddrCmd = 1'b0;
		case (shiftNext)
			`SFCFE_OP_READ, `SFCFE_OP_FREAD, `SFCFE_OP_RDSR: rdCmd = 1'b1;
			`SFCFE_OP_DREAD, `SFCFE_OP_D2IO, `SFCFE_OP_D2IOW:
			begin
				rdCmd = 1'b1;
				dualCmd = 1'b1;
			end
			`SFCFE_OP_QREAD, `SFCFE_OP_Q4IO, `SFCFE_OP_Q4IOW:
			begin
				rdCmd = 1'b1;
				quadCmd = 1'b1;
				known = quadEnableBit;
			end
			`SFCFE_OP_DTRF, `SFCFE_OP_DTR2, `SFCFE_OP_DTR4:
			begin
				rdCmd = 1'b1;
				ddrCmd = 1'b1;
			end
			`SFCFE_OP_QPIEN:
			begin
				wrCmd = 1'b1;
				known = quadEnableBit && !qpiMode;
			end
			`SFCFE_OP_QPIDIS:
			begin
				wrCmd = 1'b1;
				known = qpiMode;
			end
			`SFCFE_OP_RESET_ENABLE_CMD, `SFCFE_OP_RST, `SFCFE_OP_WREN, `SFCFE_OP_WRDI,
			`SFCFE_OP_WRSR, `SFCFE_OP_SE, `SFCFE_OP_BE, `SFCFE_OP_CE, `SFCFE_OP_PP: wrCmd = 1'b1;
			default: known = 1'b0;
		endcase
	end
	wire arrayCmd = rdCmd && (shiftNext != `SFCFE_OP_RDSR);
	wire eraseProg = (opcode == `SFCFE_OP_SE) || (opcode == `SFCFE_OP_BE) ||
		(opcode == `SFCFE_OP_CE) || (opcode == `SFCFE_OP_PP);

	sfcfe_fifo #(
		.WIDTH(8),
		.DEPTH(`SFCFE_FIFO_DEPTH),
		.AW(`SFCFE_FIFO_AW)
	) rxFifo (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.flush(csFall),
		.inData(rxByte_reg),
		.inValid(rxPush_reg),
		.inReady(fifoInReady),
		.outData(rxData),
		.outValid(rxValid),
		.outReady(rxReady)
	);

	assign txReady = (state_reg == S_TX) && linkLive && sclkFall && (bitCnt_reg == 3'd0);
	// Missing tx byte is sent as all ones, first bit included
	wire [7:0] txByte = txValid ? txData : 8'hFF;
	wire [3:0] laneOe = (lanes_reg == 2'd2) ? 4'hF : (lanes_reg == 2'd1) ? 4'h3 : 4'h2;

	always @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			state_reg <= S_IDLE;
			lanes_reg <= 2'd0;
			ddr_reg <= 1'b0;
			isWrite_reg <= 1'b0;
			pause_reg <= 1'b0;
			gotRstEn_reg <= 1'b0;
			txOe_reg <= 4'h0;
			shift_reg <= 8'h00;
			txShift_reg <= 8'h00;
			bitCnt_reg <= 3'd0;
			rstCnt_reg <= 16'h0000;
			rxPush_reg <= 1'b0;
			rxByte_reg <= 8'h00;
			opcode <= 8'h00;
			cmdStart <= 1'b0;
			cmdExecute <= 1'b0;
			qpiMode <= 1'b0;
			resetBusy <= 1'b0;
			softReset <= 1'b0;
			dataLineOut <= 4'h0;
			dataLineOe <= 4'h0;
		end
		else
		begin
			cmdStart <= 1'b0;
			cmdExecute <= 1'b0;
			softReset <= 1'b0;
			rxPush_reg <= 1'b0;
			if (resetBusy)
			begin
				if (rstCnt_reg == 16'h0000)
					resetBusy <= 1'b0;
				else
					rstCnt_reg <= rstCnt_reg - 16'h0001;
			end
			// Pause follows the pin only while the clock is low, and clears at once when not allowed
			if (!csB_reg && pauseAllowed && !sclkB_reg)
				pause_reg <= !pausePin;
			else if (!pauseAllowed)
				pause_reg <= 1'b0;
			if (csRise)
			begin
				// Byte-boundary check for write-type commands
				if (state_reg == S_RX && isWrite_reg && bitCnt_reg == 3'd0 && !pause_reg)
				begin
					if (eraseProg && rangeProtected)
						cmdExecute <= 1'b0;
					else
						cmdExecute <= 1'b1;
					if (opcode == `SFCFE_OP_QPIEN)
						qpiMode <= 1'b1;
					if (opcode == `SFCFE_OP_QPIDIS)
						qpiMode <= 1'b0;
					gotRstEn_reg <= (opcode == `SFCFE_OP_RESET_ENABLE_CMD);
					if (opcode == `SFCFE_OP_RST && gotRstEn_reg)
					begin
						qpiMode <= 1'b0;
						resetBusy <= 1'b1;
						rstCnt_reg <= RESET_CYCLES[15:0] - 16'h0001;
						softReset <= 1'b1;
					end
				end
				else if (state_reg != S_IDLE)
					gotRstEn_reg <= 1'b0;
				state_reg <= S_IDLE;
				pause_reg <= 1'b0;
				dataLineOe <= 4'h0;
				lanes_reg <= 2'd0;
				ddr_reg <= 1'b0;
			end
			else if (csFall)
			begin
				state_reg <= resetBusy ? S_STANDBY : S_OPC;
				lanes_reg <= qpiMode ? 2'd2 : 2'd0;
				bitCnt_reg <= 3'd0;
				txOe_reg <= 4'h0;
				isWrite_reg <= 1'b0;
			end
			else if (pause_reg)
				dataLineOe <= 4'h0;
			else
			begin
				case (state_reg)
					S_OPC:
						if (sclkRise)
						begin
							shift_reg <= shiftNext;
							bitCnt_reg <= cntNext[2:0];
							if (byteDone)
							begin
								opcode <= shiftNext;
								if (!known || (arrayCmd && writeBusy))
									state_reg <= S_STANDBY;
								else
								begin
									cmdStart <= 1'b1;
									isWrite_reg <= wrCmd;
									ddr_reg <= ddrCmd;
									if (quadCmd)
										lanes_reg <= 2'd2;
									else if (dualCmd && !qpiMode)
										lanes_reg <= 2'd1;
									state_reg <= rdCmd ? S_TX : S_RX;
								end
							end
						end
					S_RX:
						if (step)
						begin
							shift_reg <= shiftNext;
							bitCnt_reg <= cntNext[2:0];
							if (byteDone && fifoInReady)
							begin
								rxByte_reg <= shiftNext;
								rxPush_reg <= 1'b1;
							end
						end
					S_TX:
						if (linkLive && (sclkFall || (ddr_reg && sclkRise)))
						begin
							// Load a new byte at boundary, else shift MSB first
							if (bitCnt_reg == 3'd0)
								txShift_reg <= txByte;
							else
								txShift_reg <= txShift_reg << perStep;
							bitCnt_reg <= cntNext[2:0];
							dataLineOut <= (lanes_reg == 2'd2) ? (bitCnt_reg == 3'd0 ? txByte[7:4] :
								txShift_reg[3:0]) : (lanes_reg == 2'd1) ? {2'b00,
								(bitCnt_reg == 3'd0 ? txByte[7:6] : txShift_reg[5:4])} :
								{2'b00, (bitCnt_reg == 3'd0 ? txByte[7] : txShift_reg[6]), 1'b0};
							dataLineOe <= laneOe;
							txOe_reg <= laneOe;
						end
						else
							// Held bit reappears once a pause ends
							dataLineOe <= txOe_reg;
					S_STANDBY:
						dataLineOe <= 4'h0;
					default:
						state_reg <= S_IDLE;
				endcase
			end
		end
	end
endmodule

// [sfcfe_front_end_sva.sv]
// Port checker for the serial flash front end
`timescale 1ns/100ps
`include "sfcfe_regs.vh"
module sfcfe_front_end_sva #(
	parameter RESET_CYCLES = 6000
)(
	input wire core_clk,
	input wire reset_n,
	input wire serialClk,
	input wire chipSelect_n,
	input wire [3:0] dataLineIn,
	input wire [3:0] dataLineOe,
	input wire quadEnableBit,
	input wire rangeProtected,
	input wire [7:0] opcode,
	input wire cmdStart,
	input wire cmdExecute,
	input wire qpiMode,
	input wire resetBusy,
	input wire softReset
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	int busyCnt;
	always @(posedge core_clk)
		busyCnt <= (!reset_n || !resetBusy) ? 0 : busyCnt + 1;
	sequence s_idle;
		chipSelect_n [*8];
	endsequence
	sequence s_paused;
		(!serialClk && !chipSelect_n && !dataLineIn[3] && !quadEnableBit && !qpiMode) [*8];
	endsequence
	a_reset_idle: assert property ($rose(reset_n) |-> !qpiMode && dataLineOe == 4'h0)
		else $error("mode or lines not cleared by reset");
	a_idle_quiet: assert property (s_idle |-> dataLineOe == 4'h0)
		else $error("lines driven while deselected");
	a_pause_quiet: assert property (s_paused |-> dataLineOe == 4'h0)
		else $error("lines driven during pause");
	a_exec_deselect: assert property (cmdExecute |-> chipSelect_n)
		else $error("execute inside a frame");
	a_exec_protect: assert property (cmdExecute && (opcode == `SFCFE_OP_SE || opcode == `SFCFE_OP_PP) |-> !rangeProtected)
		else $error("protected range executed");
	a_reset_follow: assert property (softReset |-> ##[0:2] resetBusy)
		else $error("no wait after reset");
	a_busy_quiet: assert property (resetBusy |-> !cmdStart)
		else $error("command taken during reset wait");
	a_busy_span: assert property ($fell(resetBusy) |-> busyCnt >= RESET_CYCLES - 1 && busyCnt <= RESET_CYCLES + 1)
		else $error("reset wait length wrong");
	a_qpi_enable: assert property ($rose(qpiMode) |-> quadEnableBit)
		else $error("four-wire mode without quad enable");
	a_narrow_lanes: assert property (!qpiMode && (opcode == `SFCFE_OP_READ || opcode == `SFCFE_OP_DREAD) |-> dataLineOe[3:2] == 2'b00)
		else $error("upper lines driven in narrow read");
endmodule
bind sfcfe_front_end sfcfe_front_end_sva #(.RESET_CYCLES(RESET_CYCLES)) i_sva (.core_clk, .reset_n, .serialClk,
	.chipSelect_n, .dataLineIn, .dataLineOe, .quadEnableBit, .rangeProtected, .opcode, .cmdStart, .cmdExecute,
	.qpiMode, .resetBusy, .softReset);

// [sfcfe_host_model.sv]
// Host serial controller model driving the flash link
`timescale 1ns/100ps
module sfcfe_host_model (
	output logic serialClk,
	output logic chipSelect_n,
	output logic [3:0] dataLineIn,
	input wire [3:0] dataLineOut,
	input wire [3:0] dataLineOe
);
	logic [3:0] hostOut = 4'hF;
	logic [3:0] hostOe = 4'h0;
	logic floatBit = 1'b0;
	logic idleHigh = 1'b0;
	initial serialClk = 1'b0;
	initial chipSelect_n = 1'b1;
	// Undriven lines toggle so stale values never look valid
	always #7 floatBit = ~floatBit;
	always @*
		for (int i = 0; i < 4; i++)
			dataLineIn[i] = dataLineOe[i] ? dataLineOut[i] : (hostOe[i] ? hostOut[i] : floatBit);
	task automatic sel(input logic mode3);
		idleHigh = mode3;
		serialClk = mode3;
		#32 chipSelect_n = 1'b0;
		hostOut = 4'hF;
		hostOe = 4'hD;
		#32;
	endtask
	// Data changes after a fall, sampled at the rise
	task automatic step(input logic [3:0] d, input logic [3:0] oe, output logic [3:0] q);
		serialClk = 1'b0;
		hostOut = d;
		hostOe = oe;
		#32 serialClk = 1'b1;
		q = dataLineIn;
		#32;
	endtask
	task automatic shift(input logic [7:0] b, input int n, output logic [7:0] r);
		logic [3:0] q;
		for (int i = 7; i > 7 - n; i--)
		begin
			step({3'b111, b[i]}, 4'hD, q);
			r[i] = q[1];
		end
	endtask
	task automatic quad(input logic [7:0] b);
		logic [3:0] q;
		step(b[7:4], 4'hF, q);
		step(b[3:0], 4'hF, q);
	endtask
	// Pause pin moves only while the clock is low
	task automatic hold(input logic on);
		serialClk = 1'b0;
		#32 hostOut[3] = ~on;
		#64;
	endtask
	task automatic desel;
		serialClk = idleHigh;
		#32 chipSelect_n = 1'b1;
		hostOe = 4'h0;
		#200;
	endtask
endmodule

// [testbench.sv]
// Self-checking bench for the serial flash front end
`timescale 1ns/100ps
`include "sfcfe_regs.vh"
module testbench;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic quadEnableBit = 1'b0;
	logic writeBusy = 1'b0;
	logic rangeProtected = 1'b0;
	logic rxReady = 1'b0;
	logic [7:0] txData = 8'hC3;
	logic txValid = 1'b1;
	logic [7:0] rd;
	wire serialClk, chipSelect_n, cmdStart, cmdExecute, rxValid, txReady, qpiMode, resetBusy, softReset;
	wire [3:0] dataLineIn, dataLineOut, dataLineOe;
	wire [7:0] opcode, rxData;
	int errors = 0;
	int n_tests = 0;
	int nStart = 0;
	int nExec = 0;
	int nSoft = 0;
	int nTake = 0;
	sfcfe_front_end #(.RESET_CYCLES(300)) i_dut (.core_clk, .reset_n, .serialClk, .chipSelect_n, .dataLineIn,
		.dataLineOut, .dataLineOe, .quadEnableBit, .writeBusy, .rangeProtected, .opcode, .cmdStart, .cmdExecute,
		.rxData, .rxValid, .rxReady, .txData, .txValid, .txReady, .qpiMode, .resetBusy, .softReset);
	sfcfe_host_model i_host (.serialClk, .chipSelect_n, .dataLineIn, .dataLineOut, .dataLineOe);
	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		if (cmdStart === 1'b1) nStart++;
		if (cmdExecute === 1'b1) nExec++;
		if (softReset === 1'b1) nSoft++;
		if (txReady === 1'b1) nTake++;
	end
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic complete_run;
		if (errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic cmd(input logic m3, input logic [7:0] op, input logic [31:0] tail, input int nb);
		i_host.sel(m3);
		i_host.shift(op, 8, rd);
		for (int i = 0; i < nb; i += 8)
			i_host.shift(tail[31 - i -: 8], (nb - i > 8) ? 8 : nb - i, rd);
		i_host.desel();
	endtask
	task automatic qcmd(input logic [7:0] op);
		i_host.sel(1'b0);
		i_host.quad(op);
		i_host.desel();
	endtask
	task automatic pop(input logic [7:0] exp);
		repeat (100) if (rxValid !== 1'b1) @(negedge core_clk);
		chk("rx byte", exp, rxData);
		@(negedge core_clk) rxReady = 1'b1;
		@(negedge core_clk) rxReady = 1'b0;
	endtask
	task automatic t_read;
		int n;
		n = nTake;
		cmd(1'b0, `SFCFE_OP_READ, 32'h123456FF, 32);
		chk("read byte", 8'hC3, rd);
		// 33 falls in the data phase start 5 bytes
		chk("bytes taken", n + 5, nTake);
		cmd(1'b0, `SFCFE_OP_PP, 32'h12345678, 32);
		for (int k = 0; k < 4; k++) pop(8'h12 + 8'h22 * k[7:0]);
		// Host samples line one only: bits 7, 5, 3, 1
		cmd(1'b0, `SFCFE_OP_DREAD, 32'h0, 8);
		chk("dual read", 8'h99, rd);
		cmd(1'b0, `SFCFE_OP_DTRF, 32'h0, 8);
		chk("double rate", 8'h99, rd);
		@(negedge core_clk) txValid = 1'b0;
		txData = 8'h5A;
		cmd(1'b0, `SFCFE_OP_READ, 32'h0, 8);
		chk("idle fill", 8'hFF, rd);
		@(negedge core_clk) txValid = 1'b1;
		txData = 8'hC3;
		cmd(1'b0, `SFCFE_OP_READ, 32'h0, 27);
		chk("lines after cut", 8'h00, dataLineOe);
		cmd(1'b0, `SFCFE_OP_PP, 32'hA5A5A5A5, 27);
		repeat (3) pop(8'hA5);
	endtask
	task automatic t_refuse;
		int n;
		n = nStart;
		cmd(1'b0, 8'hA5, 32'h0, 16);
		chk("unknown start", n, nStart);
		@(negedge core_clk) writeBusy = 1'b1;
		cmd(1'b0, `SFCFE_OP_READ, 32'h0, 24);
		chk("busy read", n, nStart);
		@(negedge core_clk) writeBusy = 1'b0;
		cmd(1'b0, `SFCFE_OP_QPIEN, 32'h0, 0);
		chk("qpi no enable", 8'h00, qpiMode);
	endtask
	task automatic t_write;
		int n;
		n = nExec;
		cmd(1'b1, `SFCFE_OP_WREN, 32'h0, 0);
		chk("mode3 exec", n + 1, nExec);
		cmd(1'b0, `SFCFE_OP_WREN, 32'h0, 3);
		chk("partial exec", n + 1, nExec);
		@(negedge core_clk) rangeProtected = 1'b1;
		cmd(1'b0, `SFCFE_OP_SE, 32'h01000000, 24);
		chk("protected exec", n + 1, nExec);
		@(negedge core_clk) rangeProtected = 1'b0;
		cmd(1'b0, `SFCFE_OP_SE, 32'h01000000, 24);
		chk("open exec", n + 2, nExec);
	endtask
	task automatic t_reset;
		int n;
		@(negedge core_clk) quadEnableBit = 1'b1;
		// Line one carries bits 5 and 1 of each byte
		cmd(1'b0, `SFCFE_OP_QREAD, 32'h0, 8);
		chk("quad read", 8'h55, rd);
		cmd(1'b0, `SFCFE_OP_QPIEN, 32'h0, 0);
		chk("qpi on", 8'h01, qpiMode);
		n = nSoft;
		qcmd(`SFCFE_OP_RESET_ENABLE_CMD);
		qcmd(`SFCFE_OP_WREN);
		qcmd(`SFCFE_OP_RST);
		chk("broken pair", n, nSoft);
		qcmd(`SFCFE_OP_RESET_ENABLE_CMD);
		qcmd(`SFCFE_OP_RST);
		chk("reset taken", n + 1, nSoft);
		n = nStart;
		cmd(1'b0, `SFCFE_OP_WREN, 32'h0, 0);
		chk("start while busy", n, nStart);
		repeat (400) if (resetBusy !== 1'b0) @(negedge core_clk);
		chk("busy ended", 8'h00, resetBusy);
		chk("qpi after reset", 8'h00, qpiMode);
		@(negedge core_clk) quadEnableBit = 1'b0;
	endtask
	task automatic t_pause;
		int n;
		@(negedge core_clk) txData = 8'h96;
		i_host.sel(1'b0);
		i_host.shift(`SFCFE_OP_READ, 8, rd);
		repeat (3) i_host.shift(8'h00, 8, rd);
		i_host.hold(1'b1);
		chk("paused lines", 8'h00, dataLineOe);
		i_host.hold(1'b0);
		i_host.shift(8'h00, 8, rd);
		chk("resumed byte", 8'h96, rd);
		i_host.hold(1'b1);
		i_host.desel();
		n = nExec;
		cmd(1'b0, `SFCFE_OP_WREN, 32'h0, 0);
		chk("after paused cut", n + 1, nExec);
	endtask
	initial
	begin
		repeat (3) @(negedge core_clk);
		reset_n = 1'b1;
		repeat (4) @(negedge core_clk);
		t_read;
		t_refuse;
		t_write;
		t_reset;
		t_pause;
		complete_run;
	end
	initial
	begin
		#300000;
		errors++;
		complete_run;
	end
endmodule
